// ===== rtl/tsr_defines.svh
// Offsets, field positions, reset values of the temperature sensor register set
`ifndef TSR_DEFINES_SVH
`define TSR_DEFINES_SVH

// Register select codes carried in the pointer byte
`define TSR_SEL_TEMP 2'h0
`define TSR_SEL_CONF 2'h1
`define TSR_SEL_HYST 2'h2
`define TSR_SEL_OVER 2'h3

// Configuration byte fields
`define TSR_CONF_SHUTDOWN 0
`define TSR_CONF_MODE 1
`define TSR_CONF_POL 2
`define TSR_CONF_FQ_LO 3
`define TSR_CONF_FQ_HI 4

// Reset values
`define TSR_CONF_RST 8'h00
`define TSR_TEMP_RST 11'h000
`define TSR_OVER_RST 16'h5000
`define TSR_HYST_RST 16'h4b00
`define TSR_PTR_RST 2'h0

// Host APB register byte addresses
`define TSR_APB_CTRL 8'h00
`define TSR_APB_WDATA 8'h04
`define TSR_APB_STATUS 8'h08
`define TSR_APB_RDATA 8'h0c

// Host control word fields
`define TSR_CTRL_WRITE 0
`define TSR_CTRL_TGT_LO 1
`define TSR_CTRL_TGT_HI 2
`define TSR_CTRL_NB_LO 3
`define TSR_CTRL_NB_HI 4

// Host status word fields
`define TSR_STAT_BUSY 0
`define TSR_STAT_DONE 1
`define TSR_STAT_STALE 2

`endif

// ===== rtl/tsr_device.sv
// Sensor end: pointer, configuration, result and limit registers with alert logic
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "tsr_defines.svh"

////////////////////////////////////////////////////////////////////////////////
// Function
// - Pointer keeps two select bits, upper zero
// - Select codes: result, config, hysteresis, overtemp
// - Pointer byte latched; later reads reuse it
// - Host sends pointer on writes, register changes
// - Pointer resets to result register
// - Host flags first result read after reset as stale
// - Config bits 7:5 reserved, writable, reset zero
// - Config bits 4:3 fault depth 1/2/4/6
// - Bit 2 alert polarity, bit 1 alert mode
// - Config bit 0 selects shutdown
// - Result read-only, 11-bit, eighth-degree steps
// - Result bits left aligned, low five zero
// - Result loaded at each conversion end outside shutdown
// - Result read returns both bytes, high first
// - One-byte read returns high byte only
// - Limits: 9-bit, half-degree, left aligned, writable
// - Limit reads return low seven bits zero
// - Upper nine result bits compared to limits
// - Overtemperature limit resets to 5000h
// - Hysteresis limit resets to 4B00h
// - Alert fires after depth consecutive trips
// - Shutdown stops conversions, clears interrupt alert
module tsr_device (
  input wire logic clock,
  input wire logic resetn,
  tsr_link_if.dev link,
  input wire logic conv_done,
  input wire logic [10:0] conv_result,
  output logic [1:0] fault_depth_sel,
  output logic alert_polarity,
  output logic alert_mode_sel,
  output logic shutdown,
  output logic [8:0] compare_value,
  output logic alert_output_o,
  output logic alert_output_oe
);

  localparam logic [15:0] OVER_RST = `TSR_OVER_RST;
  localparam logic [15:0] HYST_RST = `TSR_HYST_RST;

  tsr_pkg::tsr_dev_state_t s;
  tsr_pkg::tsr_dev_state_t next_s;

  logic take;
  logic [1:0] sel;
  logic trip;
  logic [2:0] cnt_inc;
  logic [8:0] t9;

  // Fault depth code to count of consecutive trips
  function automatic logic [2:0] fault_depth(input logic [1:0] code);
    case (code)
      2'h0: fault_depth = 3'h1;
      2'h1: fault_depth = 3'h2;
      2'h2: fault_depth = 3'h4;
      default: fault_depth = 3'h6;
    endcase
  endfunction

  // Left-aligned word image of a register
  function automatic logic [15:0] read_word(input logic [1:0] code, input tsr_pkg::tsr_dev_state_t st);
    case (code)
      `TSR_SEL_TEMP: read_word = {st.temp, 5'h00};
      `TSR_SEL_CONF: read_word = {st.conf, 8'h00};
      `TSR_SEL_HYST: read_word = {st.hyst, 7'h00};
      default: read_word = {st.over, 7'h00};
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////////

  always_comb begin
    next_s = s;
    next_s.rsp_valid = 1'b0;
    trip = 1'b0;
    cnt_inc = 3'h0;
    t9 = 9'h000;
    // A command is taken once; the answer pulse blocks a second take
    take = link.cmd_valid && !s.rsp_valid;
    sel = link.cmd_has_ptr ? link.cmd_ptr[1:0] : s.ptr;

    if (take) begin
      next_s.rsp_valid = 1'b1;
      if (link.cmd_has_ptr) begin
        next_s.ptr = link.cmd_ptr[1:0];
      end
      if (link.cmd_write) begin
        next_s.rsp_data = 16'h0000;
        if (link.cmd_nbytes != 2'h0) begin
          case (sel)
            `TSR_SEL_TEMP: begin
              next_s.temp = s.temp;
            end
            `TSR_SEL_CONF: begin
              next_s.conf = link.cmd_data[15:8];
            end
            `TSR_SEL_HYST: begin
              next_s.hyst[8:1] = link.cmd_data[15:8];
              if (link.cmd_nbytes == 2'h2) begin
                next_s.hyst[0] = link.cmd_data[7];
              end
            end
            default: begin
              next_s.over[8:1] = link.cmd_data[15:8];
              if (link.cmd_nbytes == 2'h2) begin
                next_s.over[0] = link.cmd_data[7];
              end
            end
          endcase
        end
      end else begin
        next_s.rsp_data = read_word(sel, s);
        if (link.cmd_nbytes == 2'h1) begin
          next_s.rsp_data[7:0] = 8'h00;
        end
        // Any register read releases a latched interrupt alert
        if (s.conf[`TSR_CONF_MODE]) begin
          next_s.alert_active = 1'b0;
        end
      end
    end

    // Entering shutdown releases the alert in interrupt mode only
    if (!s.conf[`TSR_CONF_SHUTDOWN] && next_s.conf[`TSR_CONF_SHUTDOWN]
        && next_s.conf[`TSR_CONF_MODE]) begin
      next_s.alert_active = 1'b0;
      next_s.fault_cnt = 3'h0;
    end

    // Conversion results are dropped while shut down; set wins over read clear
    if (conv_done && !s.conf[`TSR_CONF_SHUTDOWN]) begin
      next_s.temp = conv_result;
      t9 = conv_result[10:2];
      if (s.expect_hi) begin
        trip = $signed(t9) > $signed(s.over);
      end else begin
        trip = $signed(t9) < $signed(s.hyst);
      end
      cnt_inc = s.fault_cnt + 3'h1;
      if (!trip) begin
        next_s.fault_cnt = 3'h0;
      end else if (cnt_inc >= fault_depth(s.conf[`TSR_CONF_FQ_HI:`TSR_CONF_FQ_LO])) begin
        next_s.fault_cnt = 3'h0;
        next_s.expect_hi = !s.expect_hi;
        if (s.conf[`TSR_CONF_MODE]) begin
          next_s.alert_active = 1'b1;
        end else begin
          next_s.alert_active = s.expect_hi;
        end
      end else begin
        next_s.fault_cnt = cnt_inc;
      end
    end

    // Open drain pulls low when the pin level must be low
    next_s.alert_oe = next_s.alert_active ^ next_s.conf[`TSR_CONF_POL];
  end

  ////////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge clock) begin
    if (!resetn) begin
      s.ptr <= `TSR_PTR_RST;
      s.conf <= `TSR_CONF_RST;
      s.temp <= `TSR_TEMP_RST;
      s.over <= OVER_RST[15:7];
      s.hyst <= HYST_RST[15:7];
      s.fault_cnt <= 3'h0;
      s.expect_hi <= 1'b1;
      s.alert_active <= 1'b0;
      // Pin released in reset: no false alert at power-up
      s.alert_oe <= 1'b0;
      s.rsp_valid <= 1'b0;
      s.rsp_data <= 16'h0000;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////

  assign link.rsp_valid = s.rsp_valid;
  assign link.rsp_data = s.rsp_data;
  assign fault_depth_sel = s.conf[`TSR_CONF_FQ_HI:`TSR_CONF_FQ_LO];
  assign alert_polarity = s.conf[`TSR_CONF_POL];
  assign alert_mode_sel = s.conf[`TSR_CONF_MODE];
  assign shutdown = s.conf[`TSR_CONF_SHUTDOWN];
  assign compare_value = s.temp[10:2];
  // Open drain only ever pulls low
  assign alert_output_o = 1'b0;
  assign alert_output_oe = s.alert_oe;

endmodule

`default_nettype wire

// ===== rtl/tsr_host.sv
// Host end: APB registers that launch sensor transactions and report results
`timescale 1ns/1ps
`default_nettype none
`include "tsr_defines.svh"

module tsr_host #(
  parameter int ADDR_W = 8
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  tsr_link_if.host link
);

  tsr_pkg::tsr_host_state_t s;
  tsr_pkg::tsr_host_state_t next_s;

  logic [7:0] addr;
  logic wr_acc;
  logic [1:0] tgt;

  ////////////////////////////////////////////////////////////////////////////////

  always_comb begin
    next_s = s;
    next_s.pready = 1'b0;
    next_s.pslverr = 1'b0;
    addr = paddr[7:0];
    tgt = pwdata[`TSR_CTRL_TGT_HI:`TSR_CTRL_TGT_LO];
    wr_acc = psel && penable && s.pready && pwrite;

    // Answer one cycle after setup, so every access has one wait-free access cycle
    if (psel && !penable) begin
      next_s.pready = 1'b1;
      next_s.prdata = 32'h0000_0000;
      case (addr)
        `TSR_APB_CTRL: next_s.prdata = {27'h0, s.ctrl};
        `TSR_APB_WDATA: next_s.prdata = {16'h0, s.wdata};
        `TSR_APB_STATUS: next_s.prdata = {29'h0, s.stale, s.done, s.fsm == tsr_pkg::TSR_WAIT};
        `TSR_APB_RDATA: next_s.prdata = {16'h0, s.rdata};
        default: next_s.pslverr = 1'b1;
      endcase
    end

    if (wr_acc) begin
      case (addr)
        `TSR_APB_WDATA: next_s.wdata = pwdata[15:0];
        `TSR_APB_STATUS: begin
          if (pwdata[`TSR_STAT_DONE]) begin
            next_s.done = 1'b0;
          end
        end
        `TSR_APB_CTRL: begin
          // Start is dropped while a transaction is still open
          if (s.fsm == tsr_pkg::TSR_IDLE) begin
            next_s.ctrl = pwdata[4:0];
            next_s.fsm = tsr_pkg::TSR_WAIT;
            next_s.cmd_valid = 1'b1;
            next_s.cmd_write = pwdata[`TSR_CTRL_WRITE];
            next_s.cmd_ptr = tgt;
            next_s.cmd_nbytes = pwdata[`TSR_CTRL_NB_HI:`TSR_CTRL_NB_LO];
            next_s.cmd_data = s.wdata;
            next_s.cmd_has_ptr = pwdata[`TSR_CTRL_WRITE] || (tgt != s.known_ptr);
            next_s.known_ptr = tgt;
          end
        end
        default: next_s.wdata = s.wdata;
      endcase
    end

    // Completion sets done after any clear above, so the set wins
    if (s.fsm == tsr_pkg::TSR_WAIT && link.rsp_valid) begin
      next_s.fsm = tsr_pkg::TSR_IDLE;
      next_s.cmd_valid = 1'b0;
      next_s.done = 1'b1;
      next_s.rdata = link.rsp_data;
      next_s.stale = 1'b0;
      if (!s.cmd_write && s.cmd_ptr == `TSR_SEL_TEMP && s.cmd_nbytes != 2'h0) begin
        next_s.stale = s.first_temp;
        next_s.first_temp = 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge clock) begin
    if (!resetn) begin
      s.fsm <= tsr_pkg::TSR_IDLE;
      s.cmd_valid <= 1'b0;
      s.cmd_write <= 1'b0;
      s.cmd_has_ptr <= 1'b0;
      s.cmd_ptr <= 2'h0;
      s.cmd_nbytes <= 2'h0;
      s.cmd_data <= 16'h0000;
      s.known_ptr <= `TSR_PTR_RST;
      s.first_temp <= 1'b1;
      s.done <= 1'b0;
      s.stale <= 1'b0;
      s.rdata <= 16'h0000;
      s.ctrl <= 5'h00;
      s.wdata <= 16'h0000;
      s.pready <= 1'b0;
      s.pslverr <= 1'b0;
      s.prdata <= 32'h0000_0000;
    end else begin
      s <= next_s;
    end
  end

  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign prdata = s.prdata;
  assign link.cmd_valid = s.cmd_valid;
  assign link.cmd_write = s.cmd_write;
  assign link.cmd_has_ptr = s.cmd_has_ptr;
  assign link.cmd_ptr = {6'h00, s.cmd_ptr};
  assign link.cmd_nbytes = s.cmd_nbytes;
  assign link.cmd_data = s.cmd_data;

endmodule

`default_nettype wire

// ===== rtl/tsr_link_if.sv
// Transaction-level link between the bus host and the sensor register set
`timescale 1ns/1ps
`default_nettype none

interface tsr_link_if;
  logic cmd_valid;
  logic cmd_write;
  logic cmd_has_ptr;
  logic [7:0] cmd_ptr;
  logic [1:0] cmd_nbytes;
  logic [15:0] cmd_data;
  logic rsp_valid;
  logic [15:0] rsp_data;

  modport dev (
    input cmd_valid,
    input cmd_write,
    input cmd_has_ptr,
    input cmd_ptr,
    input cmd_nbytes,
    input cmd_data,
    output rsp_valid,
    output rsp_data
  );

  modport host (
    output cmd_valid,
    output cmd_write,
    output cmd_has_ptr,
    output cmd_ptr,
    output cmd_nbytes,
    output cmd_data,
    input rsp_valid,
    input rsp_data
  );
endinterface

`default_nettype wire

// ===== rtl/tsr_pkg.sv
// Types shared by both ends of the temperature sensor register link
package tsr_pkg;

  typedef struct packed {
    logic [1:0] ptr;
    logic [7:0] conf;
    logic [10:0] temp;
    logic [8:0] over;
    logic [8:0] hyst;
    logic [2:0] fault_cnt;
    logic expect_hi;
    logic alert_active;
    logic alert_oe;
    logic rsp_valid;
    logic [15:0] rsp_data;
  } tsr_dev_state_t;

  typedef enum logic {
    TSR_IDLE = 1'b0,
    TSR_WAIT = 1'b1
  } tsr_host_fsm_t;

  typedef struct packed {
    tsr_host_fsm_t fsm;
    logic cmd_valid;
    logic cmd_write;
    logic cmd_has_ptr;
    logic [1:0] cmd_ptr;
    logic [1:0] cmd_nbytes;
    logic [15:0] cmd_data;
    logic [1:0] known_ptr;
    logic first_temp;
    logic done;
    logic stale;
    logic [15:0] rdata;
    logic [4:0] ctrl;
    logic [15:0] wdata;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } tsr_host_state_t;

endpackage

// ===== verif/temp_sensor_register_set_test.sv
// Self-checking bench joining the host and sensor ends over the link
`timescale 1ns/1ps
`default_nettype none
`include "tsr_defines.svh"

module temp_sensor_register_set_test;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic pready, pslverr;
  logic [31:0] prdata;
  logic conv_done = 1'b0;
  logic [10:0] conv_result = 11'h000;
  logic [1:0] fault_depth_sel;
  logic alert_polarity, alert_mode_sel, shutdown, alert_output_o, alert_output_oe;
  logic [8:0] compare_value;
  logic [31:0] stat;
  int err_total = 0;
  int checked = 0;
  int cycles = 0;

  tsr_link_if link ();
  tsr_host i_tsr_host (.clock(clock), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata), .link(link));
  tsr_device i_tsr_device (.clock(clock), .resetn(resetn), .link(link), .conv_done(conv_done),
    .conv_result(conv_result), .fault_depth_sel(fault_depth_sel), .alert_polarity(alert_polarity),
    .alert_mode_sel(alert_mode_sel), .shutdown(shutdown), .compare_value(compare_value),
    .alert_output_o(alert_output_o), .alert_output_oe(alert_output_oe));
  tsr_link_chk i_tsr_link_chk (.clock(clock), .resetn(resetn), .cmd_valid(link.cmd_valid),
    .cmd_write(link.cmd_write), .cmd_has_ptr(link.cmd_has_ptr), .cmd_ptr(link.cmd_ptr),
    .cmd_nbytes(link.cmd_nbytes), .cmd_data(link.cmd_data), .rsp_valid(link.rsp_valid), .rsp_data(link.rsp_data));

  initial begin
    forever #20 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("Checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Run is under a thousand cycles; this ceiling only catches a hang
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      err_total = err_total + 1;
      give_verdict();
    end
  end

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
    output logic e);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // Only the bench timeout ends a wait for pready
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // One link transaction launched through the host registers
  task automatic xfer(input logic wr, input logic [1:0] tgt, input logic [1:0] nb, input logic [15:0] wd,
    output logic [15:0] rd);
    logic [31:0] q;
    logic e;
    apb(1'b1, `TSR_APB_WDATA, {16'h0000, wd}, q, e);
    apb(1'b1, `TSR_APB_CTRL, {27'h0, nb, tgt, wr}, q, e);
    do begin
      apb(1'b0, `TSR_APB_STATUS, 32'h0, q, e);
    end while (q[`TSR_STAT_DONE] !== 1'b1);
    stat = q;
    apb(1'b1, `TSR_APB_STATUS, 32'h2, q, e);
    apb(1'b0, `TSR_APB_RDATA, 32'h0, q, e);
    rd = q[15:0];
  endtask

  task automatic conv(input logic [10:0] r);
    @(posedge clock);
    conv_done <= 1'b1;
    conv_result <= r;
    @(posedge clock);
    conv_done <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [15:0] rd;
    logic [31:0] q;
    logic e;
    check("pin reset", alert_output_oe, 1'b0);
    check("pin drive", alert_output_o, 1'b0);
    xfer(1'b0, `TSR_SEL_TEMP, 2'h2, 16'h0, rd);
    check("first result", rd, 16'h0000);
    check("stale flag", stat[`TSR_STAT_STALE], 1'b1);
    xfer(1'b0, `TSR_SEL_CONF, 2'h1, 16'h0, rd);
    check("conf reset", rd, 16'h0000);
    xfer(1'b0, `TSR_SEL_OVER, 2'h2, 16'h0, rd);
    check("over reset", rd, 16'h5000);
    xfer(1'b0, `TSR_SEL_HYST, 2'h2, 16'h0, rd);
    check("hyst reset", rd, 16'h4b00);
    xfer(1'b0, `TSR_SEL_HYST, 2'h2, 16'h0, rd);
    check("hyst again", rd, 16'h4b00);
    apb(1'b0, 8'h10, 32'h0, q, e);
    check("unmapped err", e, 1'b1);
    check("unmapped data", q, 32'h0);
  endtask

  task automatic t_conf();
    logic [15:0] rd;
    logic [7:0] v;
    for (int i = 0; i < 4; i++) begin
      v = {3'b101, i[1:0], i[0], i[1], ~i[0]};
      xfer(1'b1, `TSR_SEL_CONF, 2'h1, {v, 8'h00}, rd);
      xfer(1'b0, `TSR_SEL_CONF, 2'h1, 16'h0, rd);
      check("conf", rd, {v, 8'h00});
      check("depth", fault_depth_sel, i[1:0]);
      check("polarity", alert_polarity, v[2]);
      check("pin idle", alert_output_oe, v[2]);
      check("mode", alert_mode_sel, v[1]);
      check("shutdown", shutdown, v[0]);
    end
    xfer(1'b1, `TSR_SEL_CONF, 2'h1, 16'h0, rd);
  endtask

  task automatic t_temp();
    logic [15:0] rd;
    conv(11'h649);
    check("compare", compare_value, 9'h192);
    xfer(1'b0, `TSR_SEL_TEMP, 2'h2, 16'h0, rd);
    check("result", rd, 16'hc920);
    check("stale clear", stat[`TSR_STAT_STALE], 1'b0);
    xfer(1'b0, `TSR_SEL_TEMP, 2'h1, 16'h0, rd);
    check("result high", rd, 16'hc900);
    xfer(1'b1, `TSR_SEL_TEMP, 2'h2, 16'h1234, rd);
    xfer(1'b0, `TSR_SEL_TEMP, 2'h2, 16'h0, rd);
    check("result kept", rd, 16'hc920);
  endtask

  // Defaults 0A0 over, 096 hyst: 0B0 trips high, 080 trips low, 09B neither
  task automatic t_alert();
    logic [15:0] rd;
    int dep[4] = '{1, 2, 4, 6};
    for (int i = 0; i < 4; i++) begin
      xfer(1'b1, `TSR_SEL_CONF, 2'h1, {3'b000, i[1:0], 11'h000}, rd);
      conv(11'h26c);
      for (int k = 1; k < dep[i]; k++) conv(11'h2c0);
      check("alert early", alert_output_oe, 1'b0);
      conv(11'h2c0);
      check("alert on", alert_output_oe, 1'b1);
      for (int k = 0; k < dep[i]; k++) conv(11'h200);
      check("alert off", alert_output_oe, 1'b0);
    end
    xfer(1'b1, `TSR_SEL_CONF, 2'h1, 16'h0200, rd);
    conv(11'h2c0);
    check("int set", alert_output_oe, 1'b1);
    xfer(1'b0, `TSR_SEL_CONF, 2'h1, 16'h0, rd);
    check("int read clr", alert_output_oe, 1'b0);
    conv(11'h200);
    check("int low trip", alert_output_oe, 1'b1);
    xfer(1'b1, `TSR_SEL_CONF, 2'h1, 16'h0300, rd);
    check("sd clears", alert_output_oe, 1'b0);
    conv(11'h2c0);
    check("sd no conv", compare_value, 9'h080);
    check("sd still clr", alert_output_oe, 1'b0);
    xfer(1'b1, `TSR_SEL_CONF, 2'h1, 16'h0, rd);
  endtask

  task automatic t_limits();
    logic [15:0] rd;
    xfer(1'b1, `TSR_SEL_OVER, 2'h2, 16'h7fff, rd);
    xfer(1'b0, `TSR_SEL_OVER, 2'h2, 16'h0, rd);
    check("over", rd, 16'h7f80);
    // Pointer-only write moves the pointer; the read that follows carries none
    xfer(1'b1, `TSR_SEL_CONF, 2'h0, 16'hffff, rd);
    xfer(1'b0, `TSR_SEL_CONF, 2'h2, 16'h0, rd);
    check("ptr only", rd, 16'h0000);
    xfer(1'b1, `TSR_SEL_HYST, 2'h2, 16'he4ff, rd);
    xfer(1'b0, `TSR_SEL_HYST, 2'h2, 16'h0, rd);
    check("hyst", rd, 16'he480);
    xfer(1'b1, `TSR_SEL_HYST, 2'h1, 16'h3200, rd);
    xfer(1'b0, `TSR_SEL_HYST, 2'h2, 16'h0, rd);
    check("hyst byte", rd, 16'h3280);
  endtask

  initial begin
    repeat (20) @(posedge clock);
    resetn <= 1'b1;
    t_reset();
    t_conf();
    t_temp();
    t_alert();
    t_limits();
    give_verdict();
  end
endmodule

`default_nettype wire

// ===== verif/tsr_link_chk.sv
// Checker watching the link between the host and sensor ends
`timescale 1ns/1ps
`default_nettype none

module tsr_link_chk (
  input wire logic clock,
  input wire logic resetn,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic cmd_has_ptr,
  input wire logic [7:0] cmd_ptr,
  input wire logic [1:0] cmd_nbytes,
  input wire logic [15:0] cmd_data,
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_data
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  logic [1:0] cur_ptr;
  wire logic take = cmd_valid && !rsp_valid;
  wire logic rd_take = take && !cmd_write;
  wire logic [1:0] sel = cmd_has_ptr ? cmd_ptr[1:0] : cur_ptr;

  // Mirror of the latched pointer, so reads without a pointer byte decode
  always_ff @(posedge clock) begin
    if (!resetn) begin
      cur_ptr <= 2'h0;
    end else if (take && cmd_has_ptr) begin
      cur_ptr <= cmd_ptr[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  a_rsp_one_pulse: assert property (take |=> rsp_valid ##1 !rsp_valid)
    else $error("response not a single cycle after request");
  a_rsp_has_cause: assert property (rsp_valid |-> $past(take))
    else $error("response without request");
  a_cmd_drop: assert property (rsp_valid |=> !cmd_valid)
    else $error("request held past response");
  a_cmd_held: assert property (take |=> cmd_valid && $stable(cmd_ptr) && $stable(cmd_data) && $stable(cmd_nbytes))
    else $error("request changed before response");
  a_ptr_upper_zero: assert property (cmd_valid |-> cmd_ptr[7:2] == 6'h00)
    else $error("pointer upper bits not zero");
  a_write_has_ptr: assert property (take && cmd_write |-> cmd_has_ptr)
    else $error("write without pointer byte");
  a_write_ans_zero: assert property (take && cmd_write |=> rsp_data == 16'h0000)
    else $error("write answer not zero");
  a_temp_low_zero: assert property (rd_take && sel == 2'h0 |=> rsp_data[4:0] == 5'h00)
    else $error("result low bits not zero");
  a_limit_low_zero: assert property (rd_take && sel[1] |=> rsp_data[6:0] == 7'h00)
    else $error("limit low bits not zero");
  a_one_byte_low: assert property (rd_take && cmd_nbytes == 2'h1 |=> rsp_data[7:0] == 8'h00)
    else $error("one byte read has second byte");

  c_write: cover property (take && cmd_write);
  c_read_no_ptr: cover property (rd_take && !cmd_has_ptr);
  c_one_byte: cover property (rd_take && cmd_nbytes == 2'h1 && sel == 2'h0);
endmodule

`default_nettype wire
